// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "uib_defines.svh"

module tb_top;
  logic clock;
  logic nrst;
  logic [1:0] rate_select;
  logic power_up_allow;
  wire logic host_serial_in;
  wire logic ir_rx_in;
  wire logic host_serial_out;
  wire logic ir_tx_out;
  wire logic init_done_line;
  wire logic call_alert_line;
  int mismatches = 0;
  int num_checks = 0;
  // Oscillator periods from reset release to running, at about 11.3 clocks each.
  localparam int START_TOSC = `UIB_POWER_UP_TIMER_TOSC + `UIB_OST_TOSC;

  // Start-up runs its full delays; only the wake count is cut to keep the run brief.
  uib_codec #(
    .WAKE_TOSC(16'h0004)
  ) dut_u (
    .clock(clock),
    .nrst(nrst),
    .rate_select(rate_select),
    .host_serial_in(host_serial_in),
    .ir_rx_in(ir_rx_in),
    .power_up_allow(power_up_allow),
    .host_serial_out(host_serial_out),
    .ir_tx_out(ir_tx_out),
    .init_done_line(init_done_line),
    .call_alert_line(call_alert_line)
  );

  uib_far_model far_u (
    .clock(clock),
    .host_serial_out(host_serial_out),
    .ir_tx_out(ir_tx_out),
    .host_serial_in(host_serial_in),
    .ir_rx_in(ir_rx_in)
  );

  // Free-running 125 MHz clock.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits, with a bound, for a byte from the IR side or from the host side.
  task automatic take(input logic from_ir, output logic [7:0] b);
    b = 8'hxx;
    for (int i = 0; i < 40 * far_u.bit_clks; i++) begin
      if (from_ir && far_u.ir_q.size() > 0) begin
        b = far_u.ir_q.pop_front();
        break;
      end
      if (!from_ir && far_u.host_q.size() > 0) begin
        b = far_u.host_q.pop_front();
        break;
      end
      @(negedge clock);
    end
  endtask

  task automatic t_reset();
    int n;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check({7'h00, host_serial_out}, 8'h01);
    check({7'h00, ir_tx_out}, 8'h00);
    check({7'h00, init_done_line}, 8'h00);
    check({7'h00, call_alert_line}, 8'h01);
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    n = 0;
    while (init_done_line !== 1'b1 && n < START_TOSC * 12) begin
      @(negedge clock);
      n++;
    end
    check({7'h00, n > START_TOSC * 11 && n < START_TOSC * 12}, 8'h01);
    check({7'h00, init_done_line}, 8'h01);
  endtask

  // Back-to-back host characters with mixed zero and one bits.
  task automatic t_host_ir();
    logic [7:0] b;
    far_u.host_send(8'ha5);
    far_u.host_send(8'h5a);
    take(1'b1, b);
    check(b, 8'ha5);
    take(1'b1, b);
    check(b, 8'h5a);
    check(far_u.bad[7:0], 8'h00);
  endtask

  // A drop of the enable mid-character must be ignored.
  task automatic t_ir_host();
    logic [7:0] b;
    fork
      far_u.ir_send(8'h3c);
      begin
        repeat (2000) @(posedge clock);
        power_up_allow <= 1'b0;
        repeat (3000) @(negedge clock);
        check({7'h00, init_done_line}, 8'h01);
        @(posedge clock);
        power_up_allow <= 1'b1;
      end
    join
    take(1'b0, b);
    check(b, 8'h3c);
    check(far_u.bad[7:0], 8'h00);
  endtask

  // Sleep on a low enable while idle, then wake after the wake count.
  task automatic t_sleep();
    repeat (far_u.bit_clks) @(posedge clock);
    power_up_allow <= 1'b0;
    repeat (8) @(negedge clock);
    check({7'h00, init_done_line}, 8'h00);
    @(posedge clock);
    power_up_allow <= 1'b1;
    repeat (25) @(negedge clock);
    check({7'h00, init_done_line}, 8'h00);
    repeat (100) @(negedge clock);
    check({7'h00, init_done_line}, 8'h01);
  endtask

  // The slower rate doubles every bit time; the monitors follow the new figure.
  task automatic t_rate2();
    logic [7:0] b;
    @(posedge clock);
    rate_select <= 2'h2;
    far_u.bit_clks = 2170;
    repeat (10) @(posedge clock);
    far_u.ir_send(8'hc3);
    take(1'b0, b);
    check(b, 8'hc3);
    check(far_u.bad[7:0], 8'h00);
  endtask

  // Main sequence; reset is held for four clocks inside the first scenario.
  initial begin
    nrst = 1'b0;
    rate_select = 2'h3;
    power_up_allow = 1'b1;
    t_reset();
    t_host_ir();
    t_ir_host();
    t_sleep();
    t_rate2();
    wrap_up();
  end

  // Cuts a hang short well past the expected length of the run.
  initial begin
    repeat (150000) @(posedge clock);
    mismatches++;
    wrap_up();
  end
endmodule

`default_nettype wire

// ===== uib_codec.sv
// How it works
// - While nrst is low the block stays reset; afterwards the start sequence runs.
// - Power-up delay then oscillator start-up delay must finish before any traffic.
// - Bit tick is derived from the oscillator, sixteen ticks per serial bit.
// - Start and data bits use bit ticks; stop bit is timed only when transmitting.
// - rate_select picks 9600, 19200, 57600 or 115200 baud on the host port.
// - Host serial port is half duplex: never sending and receiving at once.
// - A zero bit gives ir_tx_out low 7 ticks, high 3, low 6.
// - A one bit keeps ir_tx_out low for all sixteen ticks.
// - Low on ir_rx_in in the first 3 ticks of a bit decodes a zero.
// - ir_rx_in high for the whole bit time decodes a one.
// - host_serial_out holds each bit level for all sixteen ticks.
// - Bytes go to the host only after full demodulation; host bytes go to IR.
// - Output streams may lag their inputs; no bit alignment is kept.
// - A low power_up_allow puts the device into a low-power disabled state.
// - On power_up_allow high, operation resumes after 1024 oscillator periods.
// - call_alert_line carries no ring indication; it is held high.
// - A low power_up_allow is acted on only in the normal disconnect (idle) state.
// - init_done_line is high once initialised, low otherwise.
`timescale 1ns/1ps
`default_nettype none
`include "uib_defines.svh"

module uib_codec #(
  parameter logic [15:0] POWER_UP_TIMER_TOSC = `UIB_POWER_UP_TIMER_TOSC,
  parameter logic [15:0] OST_TOSC = `UIB_OST_TOSC,
  parameter logic [15:0] WAKE_TOSC = `UIB_WAKE_TOSC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] rate_select,
  input wire logic host_serial_in,
  input wire logic ir_rx_in,
  input wire logic power_up_allow,
  output logic host_serial_out,
  output logic ir_tx_out,
  output logic init_done_line,
  output logic call_alert_line
);

  logic [4:0] sync1;
  logic [4:0] sync2;
  logic hs_in;
  logic ir_in;
  logic pa_in;
  logic [1:0] rate;
  logic [27:0] osc_acc;
  logic osc_tick;
  logic [6:0] div_cnt;
  logic [6:0] div_lim;
  logic bit_tick;
  uib_pkg::uib_pwr_e pwr_state;
  logic [15:0] wait_cnt;
  logic run;
  logic ndm_idle;
  uib_pkg::uib_ser_s hrx;
  uib_pkg::uib_ser_s htx;
  uib_pkg::uib_ser_s mod;
  uib_pkg::uib_ser_s dem;
  logic dem_zero;
  logic [7:0] hold_data;
  logic hold_valid;
  logic push_valid;
  logic [7:0] push_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic hrx_start;
  logic htx_start;
  logic mod_load;

  // All input pins but nrst are foreign to this clock, so each passes two flops before use.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 5'h07;
      sync2 <= 5'h07;
    end else begin
      sync1 <= {rate_select, power_up_allow, ir_rx_in, host_serial_in};
      sync2 <= sync1;
    end
  end

  assign hs_in = sync2[0];
  assign ir_in = sync2[1];
  assign pa_in = sync2[2];
  assign rate = sync2[4:3];

  // Accumulator pulses once per 11.0592 MHz period; one clock of jitter is harmless.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      osc_acc <= 28'h0000000;
      osc_tick <= 1'b0;
    end else if (osc_acc >= `UIB_ACC_STEP) begin
      osc_acc <= osc_acc - `UIB_ACC_STEP;
      osc_tick <= 1'b1;
    end else begin
      osc_acc <= osc_acc + `UIB_OSC_HZ;
      osc_tick <= 1'b0;
    end
  end

  // Host baud rate from the rate pins, as oscillator periods per bit tick.
  always_comb begin
    case (rate)
      2'h0: div_lim = `UIB_DIV_9600;
      2'h1: div_lim = `UIB_DIV_19200;
      2'h2: div_lim = `UIB_DIV_57600;
      default: div_lim = `UIB_DIV_115200;
    endcase
  end

  // Bit tick divider; sixteen of these make one serial bit.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= 7'h00;
      bit_tick <= 1'b0;
    end else if (osc_tick && div_cnt >= div_lim - 7'h01) begin
      div_cnt <= 7'h00;
      bit_tick <= 1'b1;
    end else begin
      if (osc_tick) div_cnt <= div_cnt + 7'h01;
      bit_tick <= 1'b0;
    end
  end

  assign run = (pwr_state == uib_pkg::ST_RUN);
  // Normal disconnect state: running with no character in flight anywhere.
  assign ndm_idle = run && !hrx.active && !htx.active && !mod.active && !dem.active &&
                    !hold_valid && !fifo_out_valid && !push_valid;

  // Start-up, sleep and wake sequencing, counted in oscillator periods.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pwr_state <= uib_pkg::ST_POWER_UP_TIMER;
      wait_cnt <= 16'h0000;
    end else begin
      case (pwr_state)
        uib_pkg::ST_POWER_UP_TIMER: begin
          if (osc_tick && wait_cnt == POWER_UP_TIMER_TOSC - 16'h0001) begin
            pwr_state <= uib_pkg::ST_OST;
            wait_cnt <= 16'h0000;
          end else if (osc_tick) begin
            wait_cnt <= wait_cnt + 16'h0001;
          end
        end
        uib_pkg::ST_OST: begin
          if (osc_tick && wait_cnt == OST_TOSC - 16'h0001) begin
            pwr_state <= uib_pkg::ST_RUN;
            wait_cnt <= 16'h0000;
          end else if (osc_tick) begin
            wait_cnt <= wait_cnt + 16'h0001;
          end
        end
        uib_pkg::ST_RUN: begin
          if (ndm_idle && !pa_in) begin
            pwr_state <= uib_pkg::ST_SLEEP;
          end
        end
        uib_pkg::ST_SLEEP: begin
          if (pa_in) begin
            pwr_state <= uib_pkg::ST_WAKE;
            wait_cnt <= 16'h0000;
          end
        end
        uib_pkg::ST_WAKE: begin
          if (osc_tick && wait_cnt == WAKE_TOSC - 16'h0001) begin
            pwr_state <= uib_pkg::ST_RUN;
            wait_cnt <= 16'h0000;
          end else if (osc_tick) begin
            wait_cnt <= wait_cnt + 16'h0001;
          end
        end
        default: pwr_state <= uib_pkg::ST_POWER_UP_TIMER;
      endcase
    end
  end

  // Status pins; the ring line is a fixed high level with no behaviour.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      init_done_line <= 1'b0;
      call_alert_line <= 1'b1;
    end else begin
      init_done_line <= run;
      call_alert_line <= 1'b1;
    end
  end

  // Half duplex: the receiver starts only while the sender is idle and wins a tie.
  // The sender starts on a bit tick, so its start bit is a full sixteen ticks.
  assign hrx_start = run && !hrx.active && !htx.active && fifo_in_ready && !hs_in;
  assign htx_start = run && bit_tick && !htx.active && !hrx.active && !hrx_start &&
                     hold_valid;

  // Host receiver; a full buffer holds off start bits, the host's only back-pressure.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hrx <= '0;
      push_valid <= 1'b0;
      push_data <= 8'h00;
    end else begin
      push_valid <= 1'b0;
      if (hrx_start) begin
        hrx.active <= 1'b1;
        hrx.idx <= 4'h0;
        hrx.tick <= 4'h0;
      end else if (hrx.active && bit_tick) begin
        hrx.tick <= hrx.tick + 4'h1;
        if (hrx.tick == `UIB_SAMPLE_TICK) begin
          if (hrx.idx == 4'h0 && hs_in) begin
            hrx.active <= 1'b0;
          end else if (hrx.idx == `UIB_STOP_INDEX) begin
            hrx.active <= 1'b0;
            push_valid <= hs_in;
            push_data <= hrx.sh[9:2];
          end else if (hrx.idx != 4'h0) begin
            hrx.sh <= {hs_in, hrx.sh[9:1]};
          end
        end
        if (hrx.tick == `UIB_LAST_TICK) hrx.idx <= hrx.idx + 4'h1;
      end
    end
  end

  // The buffer decouples host arrival from IR pacing, so IR output lags.
  uib_fifo #(
    .WIDTH(`UIB_FIFO_WIDTH),
    .DEPTH(`UIB_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign fifo_out_ready = run && !mod.active && bit_tick;
  assign mod_load = fifo_out_valid && fifo_out_ready;

  // IR modulator: loaded on a bit tick, so every bit, stop included, lasts sixteen ticks.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mod <= '0;
    end else if (mod_load) begin
      mod.active <= 1'b1;
      mod.idx <= 4'h0;
      mod.tick <= 4'h0;
      mod.sh <= {1'b1, fifo_out_data, 1'b0};
    end else if (mod.active && bit_tick) begin
      mod.tick <= mod.tick + 4'h1;
      if (mod.tick == `UIB_LAST_TICK) begin
        mod.sh <= {1'b1, mod.sh[9:1]};
        mod.idx <= mod.idx + 4'h1;
        if (mod.idx == `UIB_STOP_INDEX) mod.active <= 1'b0;
      end
    end
  end

  // Pulse only in ticks 7 to 9 of a zero bit; a one bit stays dark.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ir_tx_out <= 1'b0;
    end else begin
      ir_tx_out <= mod.active && !mod.sh[0] && mod.tick >= `UIB_PULSE_FIRST &&
                   mod.tick <= `UIB_PULSE_LAST;
    end
  end

  // IR demodulator: a falling edge opens the start window; a window is zero if the line
  // was low in its first three ticks. The byte is handed over without timing the stop.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dem <= '0;
      dem_zero <= 1'b0;
      hold_valid <= 1'b0;
      hold_data <= 8'h00;
    end else begin
      if (htx_start) hold_valid <= 1'b0;
      if (run && !dem.active && !ir_in) begin
        dem.active <= 1'b1;
        dem.idx <= 4'h0;
        dem.tick <= 4'h0;
        dem_zero <= 1'b1;
      end else if (dem.active) begin
        if (!ir_in && dem.tick < `UIB_RX_ZERO_TICKS) dem_zero <= 1'b1;
        if (bit_tick) begin
          dem.tick <= dem.tick + 4'h1;
          if (dem.tick == `UIB_LAST_TICK) begin
            dem.idx <= dem.idx + 4'h1;
            dem_zero <= 1'b0;
            if (dem.idx != 4'h0) dem.sh <= {!dem_zero, dem.sh[9:1]};
            if (dem.idx == `UIB_LAST_DATA) begin
              dem.active <= 1'b0;
              hold_valid <= 1'b1;
              hold_data <= {!dem_zero, dem.sh[9:3]};
            end
          end
        end
      end
    end
  end

  // Host sender: a new byte that lands while one is held overwrites it.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      htx <= '0;
    end else if (htx_start) begin
      htx.active <= 1'b1;
      htx.idx <= 4'h0;
      htx.tick <= 4'h0;
      htx.sh <= {1'b1, hold_data, 1'b0};
    end else if (htx.active && bit_tick) begin
      htx.tick <= htx.tick + 4'h1;
      if (htx.tick == `UIB_LAST_TICK) begin
        htx.sh <= {1'b1, htx.sh[9:1]};
        htx.idx <= htx.idx + 4'h1;
        if (htx.idx == `UIB_STOP_INDEX) htx.active <= 1'b0;
      end
    end
  end

  // Line idles high and follows the shift register bit for a whole bit time.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      host_serial_out <= 1'b1;
    end else begin
      host_serial_out <= htx.active ? htx.sh[0] : 1'b1;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence wake_leave;
    (pwr_state == uib_pkg::ST_WAKE) ##1 (pwr_state == uib_pkg::ST_RUN);
  endsequence
  sequence mod_bit_end;
    mod.active && bit_tick && mod.tick == `UIB_LAST_TICK;
  endsequence

  init_level_a: assert property ((pwr_state != uib_pkg::ST_RUN) |=> !init_done_line)
    else $error("init_done_line high while not running");
  tick_wrap_a: assert property (mod_bit_end |=> mod.tick == 4'h0)
    else $error("bit did not wrap after sixteen ticks");
  pulse_place_a: assert property (ir_tx_out |-> $past(mod.active && !mod.sh[0] &&
                                  mod.tick >= 4'h7 && mod.tick <= 4'h9))
    else $error("IR pulse outside ticks 7 to 9 of a zero bit");
  one_dark_a: assert property ((mod.active && mod.sh[0]) |=> !ir_tx_out)
    else $error("IR pulse during a one bit");
  half_duplex_a: assert property (!(hrx.active && htx.active))
    else $error("host port sending and receiving at once");
  sleep_entry_a: assert property ((pwr_state == uib_pkg::ST_RUN) ##1
                                  (pwr_state == uib_pkg::ST_SLEEP) |->
                                  $past(ndm_idle && !pa_in))
    else $error("sleep entered outside the idle state");
  wake_delay_a: assert property (wake_leave |-> $past(wait_cnt) == WAKE_TOSC - 16'h0001)
    else $error("wake delay cut short");
  rx_hold_a: assert property ((htx.active && $past(htx.active) && $past(htx.active, 2) &&
                              !$past(bit_tick, 2)) |-> $stable(host_serial_out))
    else $error("host line changed inside a bit");
  tx_source_a: assert property ($rose(htx.active) |-> $past(hold_valid))
    else $error("host send without a demodulated byte");
endmodule

`default_nettype wire

// ===== uib_defines.svh
`ifndef UIB_DEFINES_SVH
`define UIB_DEFINES_SVH

// System clock rate in hertz (125 MHz, 0x7735940).
`define UIB_CLK_HZ 28'h7735940
// Oscillator rate in hertz (11.0592 MHz, 0xa8c000).
`define UIB_OSC_HZ 28'h0a8c000
// Accumulator threshold: a virtual oscillator period ends when the sum passes it.
`define UIB_ACC_STEP 28'h6ca9940

// Oscillator periods per bit tick; bit rate is Fosc/1152, /576, /192, /96 at 16 ticks.
`define UIB_DIV_9600 7'h48
`define UIB_DIV_19200 7'h24
`define UIB_DIV_57600 7'h0c
`define UIB_DIV_115200 7'h06

// Bit framing figures: bit ticks, then bit indices (UIB_LAST_DATA, UIB_STOP_INDEX).
`define UIB_LAST_TICK 4'hf
`define UIB_SAMPLE_TICK 4'h8
`define UIB_PULSE_FIRST 4'h7
`define UIB_PULSE_LAST 4'h9
`define UIB_RX_ZERO_TICKS 4'h3
`define UIB_LAST_DATA 4'h8
`define UIB_STOP_INDEX 4'h9

// Delays counted in oscillator periods.
`define UIB_POWER_UP_TIMER_TOSC 16'h0400
`define UIB_OST_TOSC 16'h0400
`define UIB_WAKE_TOSC 16'h0400

// Transmit buffer shape.
`define UIB_FIFO_WIDTH 8
`define UIB_FIFO_DEPTH 8

`endif

// ===== uib_far_model.sv
`timescale 1ns/1ps
`default_nettype none

// Behavioural host UART and IR transceiver facing the codec.
module uib_far_model (
  input wire logic clock,
  input wire logic host_serial_out,
  input wire logic ir_tx_out,
  output var logic host_serial_in,
  output var logic ir_rx_in
);
  int bit_clks = 1085;
  int bad = 0;
  logic [7:0] host_q[$];
  logic [7:0] ir_q[$];

  // Both lines idle high, as a real UART and IR receiver leave them.
  initial begin
    host_serial_in = 1'b1;
    ir_rx_in = 1'b1;
  end

  // One host character; the host keeps to the bit time that the bench selects.
  task automatic host_send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      host_serial_in <= f[i];
      repeat (bit_clks - 1) @(posedge clock);
    end
  endtask

  // Zero bits are a short low pulse at the head of the bit; the stop bit is idle high.
  task automatic ir_send(input logic [7:0] d);
    logic [8:0] f;
    f = {d, 1'b0};
    for (int i = 0; i < 9; i++) begin
      @(posedge clock);
      ir_rx_in <= f[i];
      if (!f[i]) begin
        repeat (bit_clks * 3 / 16) @(posedge clock);
        ir_rx_in <= 1'b1;
        repeat (bit_clks - 1 - bit_clks * 3 / 16) @(posedge clock);
      end else begin
        repeat (bit_clks - 1) @(posedge clock);
      end
    end
    repeat (bit_clks) @(posedge clock);
  endtask

  // Bins high cycles of the IR output per bit window, so drift of a clock or two is harmless.
  initial begin
    int hi[10];
    int w;
    int k;
    logic [9:0] v;
    forever begin
      @(negedge clock);
      if (ir_tx_out === 1'b1) begin
        for (int j = 0; j < 10; j++) hi[j] = 0;
        for (int c = 0; c < 9 * bit_clks + bit_clks * 6 / 10; c++) begin
          k = (c + bit_clks * 4 / 10) / bit_clks;
          if (ir_tx_out === 1'b1) hi[k]++;
          @(negedge clock);
        end
        w = bit_clks * 3 / 16;
        for (int j = 0; j < 10; j++) begin
          v[j] = (hi[j] == 0);
          if (hi[j] != 0 && (hi[j] < w - 4 || hi[j] > w + 4)) bad++;
        end
        if (v[0] || !v[9]) bad++;
        ir_q.push_back(v[8:1]);
      end
    end
  end

  // Host receiver: latches each bit early and demands it stand until the bit ends.
  initial begin
    logic [9:0] lvl;
    int k;
    int off;
    forever begin
      @(negedge clock);
      if (host_serial_out === 1'b0) begin
        for (int c = 0; c < 10 * bit_clks - 20; c++) begin
          k = c / bit_clks;
          off = c % bit_clks;
          if (off == 20) lvl[k] = host_serial_out;
          else if (off > 20 && off < bit_clks - 20 && host_serial_out !== lvl[k]) bad++;
          @(negedge clock);
        end
        if (lvl[0] !== 1'b0 || lvl[9] !== 1'b1) bad++;
        host_q.push_back(lvl[8:1]);
      end
    end
  end
endmodule

`default_nettype wire

// ===== uib_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module uib_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Full and empty come from the occupancy count, so they never lie.
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end

  // One storage word per entry, written when the write pointer selects it.
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) mem[i] <= '0;
      else if (push && wr_ptr == AW'(i)) mem[i] <= in_data;
    end
  end

endmodule

`default_nettype wire

// ===== uib_pkg.sv
package uib_pkg;

  // Power and sequencing states of the device.
  typedef enum logic [2:0] {
    ST_POWER_UP_TIMER,
    ST_OST,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } uib_pwr_e;

  // State of one serial engine: framing position and shift register.
  typedef struct packed {
    logic active;
    logic [3:0] idx;
    logic [3:0] tick;
    logic [9:0] sh;
  } uib_ser_s;

endpackage
